/* File: hw/dma_arb_trig.sv */
// dma software trigger, write-back qos and channel arbitration
`timescale 1ns/10ps
// What this block does
// - two-bit write-back qos selects memory priority
// - writing one with pending clear triggers channel
// - writing one while pending sets, holds bit
// - pending becoming set clears trigger bit
// - writing zero clears bit, no trigger
// - unused trigger and priority bits read zero
// - per-level enable: static or round-robin
// - round-robin field records last granted channel
// - static nonzero x: x first, then wrap
// - disabling round-robin keeps priority field
module dma_arb_trig
   import dma_arb_pkg::*;
(
   input  wire logic              CLOCK,         // 100 mhz clock
   input  wire logic              NRST,          // sync reset, low
   input  wire logic [ADDR_W-1:0] ADDR,          // register address
   input  wire logic [31:0]       WDATA,         // write data
   input  wire logic              WR,            // write strobe
   input  wire logic              RD,            // read strobe
   output logic      [31:0]       RDATA,         // read data, next cycle
   input  wire logic              WRITE_PROT,    // write protection on, trigger and priority writes only
   input  wire logic [NUM_CH-1:0] CHAN_PENDING,  // per-channel pending flag
   input  wire logic [11:0]       CHAN_LEVEL,    // 2-bit level per channel
   input  wire logic              ARB_REQ,       // engine asks for grant
   output logic [NUM_CH-1:0]      SOFT_TRIG,     // trigger pulse per channel
   output logic [QOS_W-1:0]       WRB_QOS,       // write-back qos
   output logic                   ARB_VALID,     // grant pulse
   output logic [PRI_W-1:0]       ARB_CHANNEL,   // granted channel
   output logic [1:0]             ARB_LEVEL      // level of grant
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // first requesting channel scanning upward from start, wrapping
   function automatic logic [3:0] pick_chan(input logic [5:0] req,
                                            input logic [2:0] start);
      logic [3:0] res;
      int         s;
      int         idx;
      res = 4'h0;
      s   = (start > LAST_CH) ? 0 : int'(start);
      for (int k = 0; k < NUM_CH; k++) begin
         idx = (s + k) % NUM_CH;
         if (!res[3] && req[idx]) begin
            res = {1'b1, idx[2:0]};
         end
      end
      return res;
   endfunction

   function automatic logic [2:0] pri_field(input logic [31:0] r,
                                            input int lvl);
      return r[lvl*LVL_STRIDE+PRI_POS +: PRI_W];
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   qos_t              qos_q;
   logic [5:0]        trig_q;
   logic [5:0]        trig_d;
   logic [5:0]        pulse_q;
   logic [5:0]        pulse_d;
   logic [5:0]        pend_q;
   logic [31:0]       prio_q;
   logic [31:0]       prio_d;
   logic [31:0]       rdata_q;
   logic              valid_q;
   logic [2:0]        chan_q;
   logic [1:0]        lvl_q;
   logic              wr_trig_ok;
   logic              wr_prio_ok;
   logic [5:0]        pend_rise;
   logic [5:0]        pend_fall;
   logic [5:0]        lvl_req [NUM_LVL];
   logic [3:0]        lvl_pick [NUM_LVL];
   logic [3:0]        win;
   logic [1:0]        win_lvl;
   logic [5:0]        win_req;
   logic              arb_fire;

   assign wr_trig_ok = WR && !WRITE_PROT && (ADDR == OFS_TRIG);
   assign wr_prio_ok = WR && !WRITE_PROT && (ADDR == OFS_PRIO);
   assign pend_rise  = CHAN_PENDING & ~pend_q;
   assign pend_fall  = ~CHAN_PENDING & pend_q;

   // ------------------------------------------------------------
   // write-back qos
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         qos_q <= QOS_RESET;
      end else if (WR && ADDR == OFS_QOS) begin
         qos_q <= qos_t'(WDATA[QOS_W-1:0]);
      end
   end

   // ------------------------------------------------------------
   // software trigger
   // ------------------------------------------------------------
   // a held bit fires once its channel's pending flag drops,
   // then stays set until that channel turns pending again
   always_comb begin
      trig_d  = trig_q & ~pend_rise;
      pulse_d = trig_q & pend_fall;
      if (wr_trig_ok) begin
         pulse_d = pulse_d | (WDATA[5:0] & ~CHAN_PENDING);
         trig_d  = WDATA[5:0] & CHAN_PENDING;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         trig_q  <= TRIG_RESET;
         pulse_q <= TRIG_RESET;
         pend_q  <= TRIG_RESET;
      end else begin
         trig_q  <= trig_d;
         pulse_q <= pulse_d;
         pend_q  <= CHAN_PENDING;
      end
   end

   // ------------------------------------------------------------
   // arbitration
   // ------------------------------------------------------------
   // highest level with a pending channel wins
   always_comb begin
      win     = 4'h0;
      win_lvl = 2'h0;
      win_req = 6'h0;
      for (int l = 0; l < NUM_LVL; l++) begin
         lvl_req[l] = 6'h0;
         for (int c = 0; c < NUM_CH; c++) begin
            lvl_req[l][c] = CHAN_PENDING[c] && (CHAN_LEVEL[2*c +: 2] == l[1:0]);
         end
         if (prio_q[l*LVL_STRIDE+RR_EN_POS]) begin
            // round-robin: start after last granted channel
            lvl_pick[l] = pick_chan(lvl_req[l],
               (pri_field(prio_q, l) >= LAST_CH) ? 3'h0 : pri_field(prio_q, l) + 3'h1);
         end else begin
            lvl_pick[l] = pick_chan(lvl_req[l], pri_field(prio_q, l));
         end
         if (lvl_pick[l][3]) begin
            win     = lvl_pick[l];
            win_lvl = l[1:0];
            win_req = lvl_req[l];
         end
      end
   end

   assign arb_fire = ARB_REQ && win[3];

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         valid_q <= 1'b0;
         chan_q  <= 3'h0;
         lvl_q   <= 2'h0;
      end else begin
         valid_q <= arb_fire;
         if (arb_fire) begin
            chan_q <= win[2:0];
            lvl_q  <= win_lvl;
         end
      end
   end

   // ------------------------------------------------------------
   // priority control register
   // ------------------------------------------------------------
   // a grant record wins over a software write in the same cycle
   always_comb begin
      prio_d = prio_q;
      if (wr_prio_ok) begin
         prio_d = WDATA & PRIO_RMASK;
      end
      for (int l = 0; l < NUM_LVL; l++) begin
         if (arb_fire && win_lvl == l[1:0] && prio_q[l*LVL_STRIDE+RR_EN_POS]) begin
            prio_d[l*LVL_STRIDE+PRI_POS +: PRI_W] = win[2:0];
         end
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         prio_q <= PRIO_RESET;
      end else begin
         prio_q <= prio_d;
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         rdata_q <= 32'h0000_0000;
      end else if (RD) begin
         unique case (ADDR)
            OFS_QOS:  rdata_q <= {30'h0, qos_q};
            OFS_TRIG: rdata_q <= {26'h0, trig_q} & TRIG_RMASK;
            OFS_PRIO: rdata_q <= prio_q & PRIO_RMASK;
            default:  rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign RDATA       = rdata_q;
   assign SOFT_TRIG   = pulse_q;
   assign WRB_QOS     = qos_q;
   assign ARB_VALID   = valid_q;
   assign ARB_CHANNEL = chan_q;
   assign ARB_LEVEL   = lvl_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   AST_QOS_WRITE: assert property (
      WR && ADDR == OFS_QOS |=> WRB_QOS == $past(WDATA[1:0]) ##1 WRB_QOS == $past(WDATA[1:0], 2)
         || $past(WR))
      else $error("qos write not stored");

   AST_TRIG_FIRE: assert property (
      wr_trig_ok && |(WDATA[5:0] & ~CHAN_PENDING)
         |=> (SOFT_TRIG & $past(WDATA[5:0] & ~CHAN_PENDING)) == $past(WDATA[5:0] & ~CHAN_PENDING))
      else $error("software trigger pulse missing");

   AST_TRIG_HOLD: assert property (
      wr_trig_ok |=> (trig_q & $past(WDATA[5:0] & CHAN_PENDING)) == $past(WDATA[5:0] & CHAN_PENDING))
      else $error("trigger bit not held while pending");

   AST_TRIG_CLEAR: assert property (
      !wr_trig_ok && |pend_rise |=> (trig_q & $past(pend_rise)) == 6'h00)
      else $error("trigger bit not cleared on pending");

   AST_TRIG_ZERO: assert property (
      wr_trig_ok && WDATA[5:0] == 6'h00 && pulse_d == 6'h00 |=> trig_q == 6'h00 && SOFT_TRIG == 6'h00)
      else $error("zero write left trigger state");

   AST_RSVD_ZERO: assert property (
      RD && (ADDR == OFS_TRIG || ADDR == OFS_PRIO)
         |=> (RDATA & ~(($past(ADDR) == OFS_TRIG) ? TRIG_RMASK : PRIO_RMASK)) == 32'h0)
      else $error("reserved bits read nonzero");

   AST_RR_RECORD: assert property (
      arb_fire && prio_q[win_lvl*LVL_STRIDE+RR_EN_POS]
         |=> ARB_VALID && pri_field(prio_q, int'(ARB_LEVEL)) == ARB_CHANNEL)
      else $error("round-robin grant not recorded");

   AST_STATIC_ZERO: assert property (
      arb_fire && !prio_q[win_lvl*LVL_STRIDE+RR_EN_POS] && pri_field(prio_q, int'(win_lvl)) == 3'h0
         |=> ARB_VALID && ($past(win_req) & ((6'h01 << ARB_CHANNEL) - 6'h01)) == 6'h00)
      else $error("static grant skipped a lower channel");

   AST_PRIO_STABLE: assert property (
      !wr_prio_ok && !arb_fire |=> $stable(prio_q))
      else $error("priority register changed on its own");

   AST_PROTECT: assert property (
      WR && WRITE_PROT && !arb_fire |=> $stable(prio_q) && ((trig_q & ~$past(trig_q)) == 6'h00))
      else $error("protected write took effect");

   AST_STATIC_X: assert property (
      arb_fire && !prio_q[win_lvl*LVL_STRIDE+RR_EN_POS] && win_req[pri_field(prio_q, int'(win_lvl))]
         && pri_field(prio_q, int'(win_lvl)) <= LAST_CH
         |=> ARB_CHANNEL == $past(pri_field(prio_q, int'(win_lvl))))
      else $error("static start channel not first");

endmodule

/* File: inc/dma_arb_pkg.sv */
// constants for the dma trigger and channel arbitration block
package dma_arb_pkg;

   // ------------------------------------------------------------
   // geometry
   // ------------------------------------------------------------
   localparam int NUM_CH  = 6;
   localparam int NUM_LVL = 4;
   localparam int ADDR_W  = 8;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_QOS  = 8'h0e;
   localparam logic [7:0] OFS_TRIG = 8'h10;
   localparam logic [7:0] OFS_PRIO = 8'h14;

   // ------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------
   localparam int LVL_STRIDE = 8;
   localparam int RR_EN_POS  = 7;
   localparam int PRI_POS    = 0;
   localparam int PRI_W      = 3;
   localparam int QOS_W      = 2;
   localparam logic [31:0] PRIO_RMASK  = 32'h8787_8787;
   localparam logic [31:0] TRIG_RMASK  = 32'h0000_003f;
   localparam logic [5:0]  TRIG_RESET  = 6'h00;
   localparam logic [31:0] PRIO_RESET  = 32'h0000_0000;
   localparam logic [2:0]  LAST_CH     = 3'h5;

   // ------------------------------------------------------------
   // write-back quality of service codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      QOS_BACKGROUND = 2'b00,
      QOS_BANDWIDTH  = 2'b01,
      QOS_LATENCY    = 2'b10,
      QOS_CRITICAL   = 2'b11
   } qos_t;
   localparam qos_t QOS_RESET = QOS_BANDWIDTH;

endpackage

/* File: bench/pend_model.sv */
// channel status model holding the per-channel pending flags
`timescale 1ns/10ps
module pend_model
   import dma_arb_pkg::*;
(
   input  wire logic              clk,    // clock
   input  wire logic              nrst,   // sync reset, low
   input  wire logic [NUM_CH-1:0] trig,   // soft trigger pulses
   input  wire logic [NUM_CH-1:0] set_m,  // channels to mark pending
   input  wire logic [NUM_CH-1:0] clr_m,  // channels to retire
   output logic      [NUM_CH-1:0] pend_q  // pending flags
);
   // a trigger pulse makes its channel pending one cycle later
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q | trig | set_m) & ~clr_m;
      end
   end
endmodule

/* File: bench/dma_arb_trig_test.sv */
// self-checking bench for the trigger, qos and arbitration block
`timescale 1ns/10ps
module dma_arb_trig_test
   import dma_arb_pkg::*;
;
   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [31:0]       wdata = '0;
   logic              wr = 1'b0;
   logic              rd = 1'b0;
   logic              wprot = 1'b0;
   logic [11:0]       chan_level = '0;
   logic              arb_req = 1'b0;
   logic [NUM_CH-1:0] set_m = '0;
   logic [NUM_CH-1:0] clr_m = '0;
   logic [NUM_CH-1:0] pend;
   logic [31:0]       rdata;
   logic [NUM_CH-1:0] soft_trig;
   logic [QOS_W-1:0]  wrb_qos;
   logic              arb_valid;
   logic [PRI_W-1:0]  arb_channel;
   logic [1:0]        arb_level;
   logic [NUM_CH-1:0] trig_seen;
   int                n_mismatch = 0;
   int                tests_run = 0;
   int                cycles = 0;
   int                k;

   dma_arb_trig dut (.CLOCK(clock), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .WRITE_PROT(wprot), .CHAN_PENDING(pend), .CHAN_LEVEL(chan_level),
      .ARB_REQ(arb_req), .SOFT_TRIG(soft_trig), .WRB_QOS(wrb_qos), .ARB_VALID(arb_valid),
      .ARB_CHANNEL(arb_channel), .ARB_LEVEL(arb_level));
   pend_model model (.clk(clock), .nrst(nrst), .trig(soft_trig), .set_m(set_m), .clr_m(clr_m),
      .pend_q(pend));

   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      #1 trig_seen = soft_trig;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic pend_pulse(input logic [5:0] s, input logic [5:0] c);
      @(posedge clock);
      set_m <= s;
      clr_m <= c;
      @(posedge clock);
      set_m <= '0;
      clr_m <= '0;
      #1;
   endtask
   task automatic grant(input logic [2:0] ch, input logic [1:0] lv);
      @(posedge clock);
      arb_req <= 1'b1;
      @(posedge clock);
      arb_req <= 1'b0;
      #1 chk({31'h0, arb_valid}, 32'h1);
      chk({29'h0, arb_channel}, {29'h0, ch});
      chk({30'h0, arb_level}, {30'h0, lv});
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      rd_chk(OFS_TRIG, 32'h0);
      rd_chk(OFS_PRIO, PRIO_RESET);
      rd_chk(OFS_QOS, {30'h0, QOS_RESET});
      rd_chk(8'h20, 32'h0);
      $display("test reset done");
      for (k = 0; k < 4; k++) begin
         wr_reg(OFS_QOS, 32'(k));
         rd_chk(OFS_QOS, 32'(k));
         chk({30'h0, wrb_qos}, 32'(k));
      end
      $display("test qos done");
      wr_reg(OFS_TRIG, 32'h1);
      chk({26'h0, trig_seen}, 32'h1);
      rd_chk(OFS_TRIG, 32'h0);
      wr_reg(OFS_TRIG, 32'h1);
      chk({26'h0, trig_seen}, 32'h0);
      rd_chk(OFS_TRIG, 32'h1);
      wr_reg(OFS_TRIG, 32'h0);
      chk({26'h0, trig_seen}, 32'h0);
      rd_chk(OFS_TRIG, 32'h0);
      wr_reg(OFS_TRIG, 32'h1);
      pend_pulse(6'h00, 6'h01);
      for (k = 0; k < 4 && soft_trig[0] !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      chk({31'h0, soft_trig[0]}, 32'h1);
      rd_chk(OFS_TRIG, 32'h1);
      rd_chk(OFS_TRIG, 32'h0);
      $display("test trigger done");
      pend_pulse(6'h3f, 6'h00);
      wr_reg(OFS_TRIG, 32'hffff_ffff);
      rd_chk(OFS_TRIG, TRIG_RMASK);
      wr_reg(OFS_PRIO, 32'hffff_ffff);
      rd_chk(OFS_PRIO, PRIO_RMASK);
      @(posedge clock);
      wprot <= 1'b1;
      wr_reg(OFS_PRIO, 32'h0);
      wr_reg(OFS_TRIG, 32'h0);
      rd_chk(OFS_PRIO, PRIO_RMASK);
      rd_chk(OFS_TRIG, TRIG_RMASK);
      @(posedge clock);
      wprot <= 1'b0;
      wr_reg(OFS_TRIG, 32'h0);
      wr_reg(OFS_PRIO, 32'h0);
      pend_pulse(6'h00, 6'h3f);
      $display("test reserved and protect done");
      pend_pulse(6'h06, 6'h00);
      grant(3'h1, 2'h0);
      wr_reg(OFS_PRIO, 32'h3);
      pend_pulse(6'h01, 6'h00);
      grant(3'h0, 2'h0);
      @(posedge clock);
      chan_level <= 12'h00c;
      grant(3'h1, 2'h3);
      @(posedge clock);
      chan_level <= 12'h000;
      wr_reg(OFS_PRIO, 32'h80);
      grant(3'h1, 2'h0);
      grant(3'h2, 2'h0);
      rd_chk(OFS_PRIO, 32'h82);
      grant(3'h0, 2'h0);
      rd_chk(OFS_PRIO, 32'h80);
      grant(3'h1, 2'h0);
      wr_reg(OFS_PRIO, 32'h1);
      grant(3'h1, 2'h0);
      rd_chk(OFS_PRIO, 32'h1);
      wr_reg(OFS_PRIO, 32'h2);
      grant(3'h2, 2'h0);
      rd_chk(OFS_PRIO, 32'h2);
      pend_pulse(6'h00, 6'h3f);
      @(posedge clock);
      arb_req <= 1'b1;
      @(posedge clock);
      arb_req <= 1'b0;
      #1 chk({31'h0, arb_valid}, 32'h0);
      chk({29'h0, arb_channel}, 32'h2);
      $display("test arbitration done");
      tally_and_finish();
   end
endmodule
